// ===== rtl/lpc_flash_select_and_status.v
// Cycle select, write-status reporting and general input register of an LPC flash
//
// Behaviour
// - Four strap pins give a four-bit identity; sixteen devices can share the bus.
// - Identity zero is the boot device; its registers sit at boot addresses.
// - Firmware memory cycles: select field must equal straps, else cycle ignored.
// - LPC memory cycles: address identity bits must be inverted straps, else ignored.
// - Small variant uses address bits 21..18; larger ones bit 23 and 21..19.
// - Bits 7 and 6 of read data report program or erase completion.
// - During a byte program, bit 7 reads as the complement of the programmed value.
// - After completion the full byte is valid on reads after one microsecond.
// - During an erase bit 7 reads zero; after it, one.
// - Status need not be correct for reads outside the valid address range.
// - Each read during program or erase inverts bit 6; toggling stops on completion.
// - Unused register locations read as zero.
// - Register reads and writes are ignored while program or erase runs.
// - General input register returns the five input pin levels, no stored value.
// - Boot device decodes the input register at the fixed address; others move with identity.
// - Address bit 22 selects array when one, register space when zero.
`timescale 1ns/1ps
`include "lpc_flash_select_map.vh"
module lpc_flash_select_and_status #(
    parameter SMALL_DENSITY = 0 // 1 selects the smallest density variant
) (
    input wire sys_clk,                    // 200 MHz clock
    input wire reset_n,                    // Synchronous reset, active low
    input wire [3:0] identity_straps,      // Identity strap pins
    input wire [4:0] general_input_pins,   // General input pins
    input wire cycleStart,                 // Pulse: framing saw a new cycle start
    input wire reqValid,                   // Pulse: decoded request fields valid
    input wire reqFirmware,                // 1 firmware memory cycle, 0 LPC memory cycle
    input wire [3:0] firmware_cycle_target_field, // Select field of a firmware cycle
    input wire [31:0] reqAddr,             // Cycle address
    input wire reqWrite,                   // 1 write, 0 read
    input wire [7:0] reqData,              // Write data
    input wire opBusy,                     // Core program or erase running
    input wire opIsErase,                  // Running operation is an erase
    input wire [7:0] opData,               // Byte being programmed
    input wire [7:0] arrayData,            // Array read data from the core
    output reg cycleClaimed,               // Pulse: request addressed to this device
    output reg busRelease,                 // Level: device leaves the bus undriven
    output reg arrayReadStrobe,            // Pulse: array read issued to core
    output reg arrayWriteStrobe,           // Pulse: array write issued to core
    output reg [21:0] arrayAddr,           // Array address to core
    output reg [7:0] arrayWriteData,       // Array write data to core
    output reg readValid,                  // Pulse: readData holds the answer
    output reg [7:0] readData              // Read answer
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    wire [3:0] identity;
    wire [4:0] gpiLevels;

    pin_sync #(.WIDTH(4)) strapSync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pinIn(identity_straps),
        .syncOut(identity)
    );

    pin_sync #(.WIDTH(5)) gpiSync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pinIn(general_input_pins),
        .syncOut(gpiLevels)
    );

    // ---------------------------------------------------------------
    // Identity decode
    // ---------------------------------------------------------------
    function [3:0] addrIdentity;
        input [31:0] addr;
        begin
            if (SMALL_DENSITY != 0)
                addrIdentity = addr[21:18];
            else
                addrIdentity = {addr[`ID_BIT_LARGE_HIGH], addr[21:19]};
        end
    endfunction

    function [21:0] idMask;
        input dummy;
        begin
            idMask = (SMALL_DENSITY != 0) ? `ID_BITS_SMALL_MASK : `ID_BITS_LARGE_MASK;
        end
    endfunction

    wire fwMatch = (firmware_cycle_target_field == identity);
    wire lpcMatch = (addrIdentity(reqAddr) == ~identity);
    wire idMatch = reqFirmware ? fwMatch : lpcMatch;
    wire isArray = reqAddr[`SPACE_SELECT_BIT];
    wire isBoot = (identity == `BOOT_IDENTITY);

    // Boot device decodes the full offset; other devices mask their identity bits out
    // of the compare, so the register moves with the identity
    localparam [31:0] GPI_ADDR = `GENERAL_INPUT_LEVELS_ADDR;
    wire gpiBootHit = (reqAddr[21:0] == GPI_ADDR[21:0]);
    wire gpiMovedHit = ((reqAddr[21:0] & ~idMask(1'b0)) == (GPI_ADDR[21:0] & ~idMask(1'b0)));
    wire gpiHit = isBoot ? gpiBootHit : gpiMovedHit;

    // ---------------------------------------------------------------
    // Status tracking
    // ---------------------------------------------------------------
    reg ignoring;
    reg toggleState;
    reg busyLast;
    reg [`SETTLE_COUNT_WIDTH-1:0] settleCount;
    localparam [`SETTLE_COUNT_WIDTH-1:0] SETTLE_LOAD = `DATA_SETTLE_CYCLES;

    wire accept = reqValid && !ignoring && idMatch;
    wire mismatch = reqValid && !ignoring && !idMatch;

    // ---------------------------------------------------------------
    // Read answer selection
    // ---------------------------------------------------------------
    // Busy reads carry only the status pair; the low six bits read zero because the
    // array word under a running write is not trustworthy
    function [7:0] statusByte;
        input erasing;
        input [7:0] progByte;
        input toggleNow;
        begin
            statusByte = 8'h00;
            statusByte[`POLL_BIT] = erasing ? 1'b0 : ~progByte[`POLL_BIT];
            statusByte[`TOGGLE_BIT] = toggleNow;
        end
    endfunction

    reg [7:0] next_readData;

    always @* begin
        next_readData = `UNUSED_REG_VALUE;
        if (isArray) begin
            if (opBusy) begin
                // Status holds regardless of address range
                next_readData = statusByte(opIsErase, opData, toggleState);
            end else if (settleCount != {`SETTLE_COUNT_WIDTH{1'b0}}) begin
                // Low bits not yet trusted, only the status pair is driven
                next_readData = arrayData & 8'hc0;
            end else begin
                next_readData = arrayData;
            end
        end else if (opBusy) begin
            next_readData = `UNUSED_REG_VALUE;
        end else if (gpiHit) begin
            // Pass-through: levels are taken when the read is accepted, nothing is stored
            next_readData = {3'b000, gpiLevels};
        end else begin
            next_readData = `UNUSED_REG_VALUE;
        end
    end

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            busyLast <= 1'b0;
            settleCount <= {`SETTLE_COUNT_WIDTH{1'b0}};
        end else begin
            busyLast <= opBusy;
            if (busyLast && !opBusy)
                settleCount <= SETTLE_LOAD;
            else if (settleCount != {`SETTLE_COUNT_WIDTH{1'b0}})
                settleCount <= settleCount - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Request handling
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            ignoring <= 1'b0;
            busRelease <= 1'b1;
            cycleClaimed <= 1'b0;
            arrayReadStrobe <= 1'b0;
            arrayWriteStrobe <= 1'b0;
            arrayAddr <= 22'h000000;
            arrayWriteData <= 8'h00;
            readValid <= 1'b0;
            readData <= 8'h00;
        end else begin
            cycleClaimed <= 1'b0;
            arrayReadStrobe <= 1'b0;
            arrayWriteStrobe <= 1'b0;
            readValid <= 1'b0;
            if (cycleStart) begin
                ignoring <= 1'b0;
                busRelease <= 1'b1;
            end else if (mismatch) begin
                // Stay off the shared bus until framing reports a new cycle
                ignoring <= 1'b1;
                busRelease <= 1'b1;
            end else if (accept) begin
                cycleClaimed <= 1'b1;
                busRelease <= 1'b0;
                arrayAddr <= reqAddr[21:0];
                if (isArray) begin
                    if (reqWrite) begin
                        // Core itself refuses new writes while it is busy
                        arrayWriteStrobe <= 1'b1;
                        arrayWriteData <= reqData;
                    end else begin
                        arrayReadStrobe <= 1'b1;
                        readValid <= 1'b1;
                        readData <= next_readData;
                    end
                end else if (!reqWrite) begin
                    // Register writes have no target here and are dropped
                    readValid <= 1'b1;
                    readData <= next_readData;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Toggle bit
    // ---------------------------------------------------------------
    // Restarts from zero whenever the core is idle, so each operation begins alike
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            toggleState <= 1'b0;
        end else if (accept && !cycleStart && isArray && !reqWrite && opBusy) begin
            toggleState <= ~toggleState;
        end else if (!opBusy) begin
            toggleState <= 1'b0;
        end
    end
endmodule // lpc_flash_select_and_status

// ===== rtl/lpc_flash_select_map.vh
// Address, field and timing constants for the LPC flash select and status block
`ifndef LPC_FLASH_SELECT_MAP_VH
`define LPC_FLASH_SELECT_MAP_VH

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define GENERAL_INPUT_LEVELS_ADDR 32'hffbc0100
`define SPACE_SELECT_BIT 22
`define BOOT_IDENTITY 4'h0
`define ID_BITS_SMALL_MASK 22'h3c0000
`define ID_BITS_LARGE_MASK 22'h380000
`define ID_BIT_LARGE_HIGH 23
`define UNUSED_REG_VALUE 8'h00

// ---------------------------------------------------------------
// Status bit positions
// ---------------------------------------------------------------
`define POLL_BIT 7
`define TOGGLE_BIT 6

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define DATA_SETTLE_NS 1000
// One microsecond at the 5 ns clock, sized to the settle counter
`define DATA_SETTLE_CYCLES 8'hc8
`define SETTLE_COUNT_WIDTH 8

`endif

// ===== rtl/pin_sync.v
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 4
) (
    input wire sys_clk,            // System clock
    input wire reset_n,            // Synchronous reset, active low
    input wire [WIDTH-1:0] pinIn,  // Asynchronous pin levels
    output reg [WIDTH-1:0] syncOut // Levels after two flops
);
    reg [WIDTH-1:0] firstStage;

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            firstStage <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            firstStage <= pinIn;
            syncOut <= firstStage;
        end
    end
endmodule // pin_sync

// ===== testbench/lpc_flash_select_and_status_chk.sv
// Assertion checker for the LPC flash select and status block
`timescale 1ns/1ps
module lpc_flash_select_and_status_chk (
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [3:0] identity_straps, // Straps
    input wire logic cycleStart, // Start
    input wire logic reqValid, // Request
    input wire logic reqFirmware, // Type
    input wire logic [3:0] firmware_cycle_target_field, // Select
    input wire logic [31:0] reqAddr, // Address
    input wire logic reqWrite, // Write
    input wire logic opBusy, // Busy
    input wire logic opIsErase, // Erase
    input wire logic [7:0] opData, // Program byte
    input wire logic cycleClaimed, // Claim
    input wire logic busRelease, // Release
    input wire logic arrayReadStrobe, // Read strobe
    input wire logic arrayWriteStrobe, // Write strobe
    input wire logic readValid, // Read valid
    input wire logic [7:0] readData // Read data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire fwMiss = reqValid && reqFirmware && !cycleStart && firmware_cycle_target_field != identity_straps;
    AST_CLAIM_CAUSE: assert property (cycleClaimed |-> $past(reqValid) && !$past(cycleStart))
        else $error("claim without request");
    AST_FW_MISS: assert property (fwMiss |=> !cycleClaimed && busRelease)
        else $error("select mismatch claimed");
    AST_CLAIM_DRIVE: assert property (cycleClaimed |-> !busRelease)
        else $error("claim while released");
    AST_RD_PAIR: assert property (arrayReadStrobe |-> cycleClaimed && readValid && !$past(reqWrite))
        else $error("array read without claim");
    AST_REG_WRITE: assert property ($past(reqValid && reqWrite && !reqAddr[22]) |-> !arrayWriteStrobe && !readValid)
        else $error("register write reached array");
    AST_ERASE_POLL: assert property (arrayReadStrobe && $past(opBusy && opIsErase) |-> !readData[7])
        else $error("erase poll bit high");
    AST_PROG_POLL: assert property (arrayReadStrobe && $past(opBusy && !opIsErase) |-> readData[7] != $past(opData[7]))
        else $error("program poll bit not inverted");
    AST_REG_BUSY: assert property (readValid && !arrayReadStrobe && $past(opBusy) |-> readData == 8'h00)
        else $error("register read while busy");
    AST_BUSY_LOW: assert property (arrayReadStrobe && $past(opBusy) |-> readData[5:0] == 6'h00)
        else $error("busy read low bits set");
    cover property (arrayReadStrobe && readData[6]);
    cover property (fwMiss);
    cover property (arrayWriteStrobe);
endmodule // lpc_flash_select_and_status_chk

// ===== testbench/lpc_host_model.sv
// Host chipset bus controller model issuing decoded requests
`timescale 1ns/1ps
module lpc_host_model (
    input wire logic sys_clk, // Clock
    output logic cycleStart, // Start pulse
    output logic reqValid, // Request pulse
    output logic reqFirmware, // Cycle type
    output logic [3:0] firmware_cycle_target_field, // Select
    output logic [31:0] reqAddr, // Address
    output logic reqWrite, // Direction
    output logic [7:0] reqData // Write data
);
    initial {cycleStart, reqValid, reqFirmware, firmware_cycle_target_field, reqAddr, reqWrite, reqData} = '0;
    // Select, address and data go to their inverse after the taking edge so a late sample cannot pass
    task access(input logic fw, input logic [3:0] sel, input logic [31:0] a, input logic wr, input logic [7:0] d,
                input logic st);
        @(posedge sys_clk) #1;
        cycleStart = st;
        @(posedge sys_clk) #1;
        cycleStart = 1'b0;
        {reqValid, reqFirmware, firmware_cycle_target_field, reqAddr, reqWrite, reqData} = {1'b1, fw, sel, a, wr, d};
        @(posedge sys_clk) #1;
        {reqValid, firmware_cycle_target_field, reqAddr, reqData} = {1'b0, ~sel, ~a, ~d};
    endtask
endmodule // lpc_host_model

// ===== testbench/lpc_flash_select_and_status_tb.sv
// Self-checking testbench for the LPC flash select and status block
`timescale 1ns/1ps
module lpc_flash_select_and_status_tb;
    logic sys_clk, reset_n, cycleStart, reqValid, reqFirmware, reqWrite, opBusy, opIsErase;
    logic cycleClaimed, busRelease, arrayReadStrobe, arrayWriteStrobe, readValid;
    logic [3:0] identity_straps, firmware_cycle_target_field;
    logic [4:0] general_input_pins;
    logic [31:0] reqAddr;
    logic [7:0] reqData, opData, arrayData, arrayWriteData, readData, r1;
    logic [21:0] arrayAddr;
    int err_total, checks_done;
    lpc_host_model i_lpc_host_model (.*);
    lpc_flash_select_and_status i_lpc_flash_select_and_status (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task acc(input logic fw, input logic [3:0] sel, input logic [31:0] a, input logic wr, input logic st);
        i_lpc_host_model.access(fw, sel, a, wr, 8'ha5, st);
    endtask
    task t_select;
        acc(1, 4'h5, 32'hffc12345, 0, 1); chk("fw claim", 1, cycleClaimed);
        chk("fw data", 8'h3c, readData);
        chk("fw strobes", 3'b110, {arrayReadStrobe, readValid, arrayWriteStrobe});
        chk("fw addr", 22'h012345, arrayAddr);
        chk("fw drive", 0, busRelease);
        acc(1, 4'h6, 32'hffc00000, 0, 1); chk("miss claim", 0, cycleClaimed);
        chk("miss release", 1, busRelease);
        acc(1, 4'h5, 32'hffc00000, 0, 0); chk("ignored", 0, cycleClaimed);
        acc(0, 4'h0, 32'hffd00000, 1, 1); chk("lpc write", 1, arrayWriteStrobe);
        chk("write data", 8'ha5, arrayWriteData);
        acc(0, 4'h0, 32'hff500000, 0, 1); chk("lpc miss", 0, cycleClaimed);
    endtask
    task t_regs;
        identity_straps = 4'h0;
        general_input_pins = 5'h15;
        repeat (4) @(posedge sys_clk);
        acc(0, 4'h0, 32'hfff80000, 0, 1); chk("boot claim", 1, cycleClaimed);
        acc(0, 4'h0, 32'hffbc0100, 0, 1); chk("input levels", 8'h15, readData);
        chk("input valid", 1, readValid);
        acc(1, 4'h0, 32'hffbc0104, 0, 1); chk("unused reg", 8'h00, readData);
        acc(0, 4'h0, 32'hffbc0100, 1, 1); chk("reg write", 3'b100, {cycleClaimed, readValid, arrayWriteStrobe});
    endtask
    task t_status;
        {opBusy, opIsErase, opData, arrayData} = {2'b10, 8'h80, 8'h55};
        acc(0, 4'h0, 32'hfff80000, 0, 1); chk("prog poll", 0, readData[7]);
        chk("busy low bits", 0, readData[5:0]);
        r1 = readData;
        acc(0, 4'h0, 32'hfff80000, 0, 1); chk("toggle", {7'h00, ~r1[6]}, readData[6]);
        r1 = readData;
        acc(0, 4'h0, 32'hffbc0100, 0, 1); chk("busy reg", 8'h00, readData);
        opData = 8'h00;
        acc(0, 4'h0, 32'hfff80000, 0, 1); chk("prog poll high", 1, readData[7]);
        chk("toggle again", {7'h00, ~r1[6]}, readData[6]);
        r1 = readData;
        opIsErase = 1'b1;
        acc(1, 4'h0, 32'hffc00000, 0, 1); chk("erase poll", 0, readData[7]);
        chk("erase toggle", {7'h00, ~r1[6]}, readData[6]);
        // Core now returns an erased location
        {opBusy, arrayData} = {1'b0, 8'hff};
        repeat (2) begin
            acc(0, 4'h0, 32'hfff80000, 0, 1); chk("settling", 8'hc0, readData);
        end
        repeat (205) @(posedge sys_clk);
        acc(0, 4'h0, 32'hfff80000, 0, 1); chk("settled", 8'hff, readData);
    endtask
    task t_reset;
        acc(0, 4'h0, 32'hfff80000, 0, 1); chk("pre reset drive", 0, busRelease);
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk("mid reset release", 1, busRelease);
        chk("mid reset data", 8'h00, readData);
        chk("mid reset addr", 22'h000000, arrayAddr);
        repeat (2) @(posedge sys_clk);
        #1 chk("post reset pulses", 0, {cycleClaimed, readValid, arrayReadStrobe, arrayWriteStrobe});
        acc(0, 4'h0, 32'hfff80000, 0, 1); chk("post reset claim", 1, cycleClaimed);
        chk("post reset data", 8'hff, readData);
    endtask
    task end_sim;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {reset_n, opBusy, opIsErase, opData, identity_straps, general_input_pins, arrayData} = {3'b0, 8'h00, 4'h5, 5'h0a, 8'h3c};
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk("reset release", 1, busRelease);
        repeat (3) @(posedge sys_clk);
        t_select;
        t_regs;
        t_status;
        t_reset;
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        end_sim;
    end
endmodule // lpc_flash_select_and_status_tb
bind lpc_flash_select_and_status lpc_flash_select_and_status_chk i_chk (.*);
